// File: pkg/dcpt_defs.svh
// constants for the debug command and pipeline tracking block
// assumes inclusion by bare name from package and design files
`ifndef DCPT_DEFS_SVH
`define DCPT_DEFS_SVH
// ---------------------------------------------------------------
// command opcodes
// ---------------------------------------------------------------
`define DCPT_OP_CALL 16'h0800
`define DCPT_OP_RST 16'h0400
`define DCPT_OP_NOP 16'h0000
// ---------------------------------------------------------------
// response values, 17 bits
// ---------------------------------------------------------------
`define DCPT_RESP_DONE 17'h0_FFFF
`define DCPT_RESP_BERR 17'h1_0001
`define DCPT_RESP_ILL 17'h1_0000
// ---------------------------------------------------------------
// timing counts in clock cycles
// ---------------------------------------------------------------
`define DCPT_RST_CYCLES 10'h200
`define DCPT_FETCH_ONE 4'h1
`define DCPT_FETCH_FLUSH 4'h2
`define DCPT_FETCH_MAX 4'h7
`endif

// File: pkg/dcpt_pkg.sv
// types shared by the tracking block and its pipeline model
// assumes dcpt_defs.svh on the include path
`include "dcpt_defs.svh"
package dcpt_pkg;
    // one instruction word
    typedef logic [15:0] dcpt_word_t;
    // one fetched bus word
    typedef logic [31:0] dcpt_long_t;
    // serial response value
    typedef logic [16:0] dcpt_resp_t;
    // command sequencer states, one-hot
    typedef enum logic [2:0] {
        DCPT_ST_IDLE = 3'b001,
        DCPT_ST_STACK = 3'b010,
        DCPT_ST_RESET = 3'b100
    } dcpt_state_t;
endpackage : dcpt_pkg

// File: src/dcpt_pipe.sv
// three-stage instruction queue model: two prefetch words,
// decode word and execute word with validity bits
// assumes all inputs come from core logic on clk_sys_i
`timescale 1ns/1ns
module dcpt_pipe (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic fetch_i,
    input wire logic flush_i,
    input wire logic fetch_long_i,
    input wire dcpt_pkg::dcpt_long_t fetch_data_i,
    input wire logic use_i,
    input wire logic start_i,
    output dcpt_pkg::dcpt_word_t exe_reg_o,
    output logic exe_valid_o,
    output logic dec_valid_o
);
    import dcpt_pkg::*;
    // ---------------------------------------------------------------
    // stage storage
    // ---------------------------------------------------------------
    dcpt_word_t prim_r, prim_nxt; // prefetch_reg_primary
    dcpt_word_t low_r, low_nxt; // prefetch_reg_low
    dcpt_word_t dec_r, dec_nxt; // decode_reg
    dcpt_word_t exe_r, exe_nxt; // execute_reg
    logic prim_v_r, prim_v_nxt;
    logic low_v_r, low_v_nxt;
    logic dec_v_r, dec_v_nxt;
    logic exe_v_r, exe_v_nxt;
    // ---------------------------------------------------------------
    // next stage contents
    // ---------------------------------------------------------------
    always_comb begin
        prim_nxt = prim_r;
        low_nxt = low_r;
        dec_nxt = dec_r;
        exe_nxt = exe_r;
        prim_v_nxt = prim_v_r;
        low_v_nxt = low_v_r;
        dec_v_nxt = dec_v_r;
        exe_v_nxt = exe_v_r;
        if (flush_i) begin
            // empty queue, refilled by this fetch
            prim_v_nxt = 1'b0;
            low_v_nxt = 1'b0;
            dec_v_nxt = 1'b0;
            exe_v_nxt = 1'b0;
        end else begin
            if (start_i) begin
                exe_nxt = dec_r;
                exe_v_nxt = dec_v_r;
            end
            if (start_i || use_i || !dec_v_r) begin
                if (prim_v_r) begin
                    dec_nxt = prim_r;
                    dec_v_nxt = 1'b1;
                    prim_v_nxt = 1'b0;
                end else if (low_v_r) begin
                    dec_nxt = low_r;
                    dec_v_nxt = 1'b1;
                    low_v_nxt = 1'b0;
                end else begin
                    dec_v_nxt = 1'b0;
                end
            end
        end
        // prefetch loading, flush carries a fetch
        if (fetch_i || flush_i) begin
            prim_v_nxt = 1'b1;
            if (fetch_long_i) begin
                prim_nxt = fetch_data_i[31:16];
                low_nxt = fetch_data_i[15:0];
                low_v_nxt = 1'b1;
            end else begin
                prim_nxt = fetch_data_i[15:0];
            end
        end
    end
    // ---------------------------------------------------------------
    // stage registers
    // ---------------------------------------------------------------
    // queue state
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prim_r <= 16'h0000;
            low_r <= 16'h0000;
            dec_r <= 16'h0000;
            exe_r <= 16'h0000;
            prim_v_r <= 1'b0;
            low_v_r <= 1'b0;
            dec_v_r <= 1'b0;
            exe_v_r <= 1'b0;
        end else begin
            prim_r <= prim_nxt;
            low_r <= low_nxt;
            dec_r <= dec_nxt;
            exe_r <= exe_nxt;
            prim_v_r <= prim_v_nxt;
            low_v_r <= low_v_nxt;
            dec_v_r <= dec_v_nxt;
            exe_v_r <= exe_v_nxt;
        end
    end
    assign exe_reg_o = exe_r;
    assign exe_valid_o = exe_v_r;
    assign dec_valid_o = dec_v_r;
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_PIPE_ADV: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_i && !flush_i && dec_v_r |=> exe_v_r && exe_r == $past(dec_r))
        else $error("start did not move decode word to execute");
    AST_PIPE_AUTO: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !flush_i && !dec_v_r && prim_v_r |=> dec_v_r && dec_r == $past(prim_r))
        else $error("primary word did not fall into empty decode");
    AST_PIPE_LOW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !flush_i && (start_i || use_i || !dec_v_r) && prim_v_r && low_v_r && !fetch_i
        |=> low_v_r && !prim_v_r)
        else $error("low word taken before primary word");
endmodule : dcpt_pipe

// File: src/dcpt_top.sv
// debug command tail and deterministic opcode tracking pins
// What this block does
// - patch call operand becomes new program counter
// - stack return counter, then flush and leave debug in one cycle
// - stacking error: error reply, stay in debug
// - reset command drives reset out 512 cycles
// - core itself never reset by that command
// - done reply loaded after reset out releases
// - no-operation changes nothing, replies done
// - unknown opcode acts nop, replies illegal
// - fetch indicator low one cycle per fetch
// - fetch indicator low two cycles on flush
// - user and supervisor fetches flagged alike
// - flush then fetch gives three low cycles
// - pipeline modelled as three-stage word queue
// - low prefetch only on long fetch
// - decode loads primary before low word
// - use indicator invalidates then refills decode
// - start indicator triggers full pipeline advance
// - prefetched words fall into an empty decode stage
// - loaded stage valid, supplying stage cleared
// - pipe indicators follow system clock only
// - debug mode: serial out on start pin
// - loop mode: fetch flag stops at recirculation
// - normal fetch flagging resumes after loop
// assumes all inputs are from core logic on clk_sys_i;
// opcodes of other debug commands are flagged by the decoder
`timescale 1ns/1ns
`include "dcpt_defs.svh"
module dcpt_top (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire dcpt_pkg::dcpt_word_t cmd_opcode_i,
    input wire logic cmd_other_i,
    input wire dcpt_pkg::dcpt_long_t cmd_operand_i,
    input wire dcpt_pkg::dcpt_long_t return_pc_i,
    input wire dcpt_pkg::dcpt_long_t stack_ptr_i,
    input wire logic stack_done_i,
    input wire logic stack_err_i,
    input wire logic bdm_active_i,
    input wire logic serial_out_i,
    input wire logic loop_mode_i,
    input wire logic recirc_i,
    input wire logic fetch_i,
    input wire logic flush_i,
    input wire logic fetch_long_i,
    input wire dcpt_pkg::dcpt_long_t fetch_data_i,
    input wire logic use_i,
    input wire logic start_i,
    output logic cmd_busy_o,
    output logic resp_valid_o,
    output dcpt_pkg::dcpt_resp_t resp_data_o,
    output logic stack_req_o,
    output dcpt_pkg::dcpt_long_t stack_addr_o,
    output dcpt_pkg::dcpt_long_t stack_data_o,
    output logic pc_load_o,
    output dcpt_pkg::dcpt_long_t pc_value_o,
    output logic flush_req_o,
    output logic bdm_exit_o,
    output logic sys_reset_n_o,
    output logic fetch_ind_n_o,
    output logic pipe_use_n_o,
    output logic pipe_start_n_o,
    output dcpt_pkg::dcpt_word_t exe_reg_o,
    output logic exe_valid_o,
    output logic dec_valid_o
);
    import dcpt_pkg::*;
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    dcpt_state_t state_r; // command sequencer state
    logic busy_r; // sequencer not idle
    logic [9:0] rst_cnt_r; // reset cycles left
    logic resp_valid_r; // reply pulse
    dcpt_resp_t resp_r; // reply value
    logic stack_req_r; // stacking write held
    dcpt_long_t stack_addr_r;
    dcpt_long_t stack_data_r;
    dcpt_long_t operand_r; // patch routine start
    logic pc_load_r;
    dcpt_long_t pc_r;
    logic flush_req_r;
    logic bdm_exit_r;
    logic sys_reset_n_r; // reset out, low active
    logic [3:0] low_cnt_r; // fetch low cycles left
    logic [3:0] low_nxt; // low cycles incl. new event
    logic [3:0] add_w; // cycles a new event asks
    logic ev_gate; // fetch flagging allowed
    logic fetch_ind_n_r;
    logic pipe_use_n_r;
    logic pipe_start_n_r;
    logic cmd_take; // command accepted now
    logic is_call, is_rst, is_nop;
    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    assign cmd_take = cmd_valid_i && (state_r == DCPT_ST_IDLE);
    assign is_call = cmd_opcode_i == `DCPT_OP_CALL;
    assign is_rst = cmd_opcode_i == `DCPT_OP_RST;
    assign is_nop = cmd_opcode_i == `DCPT_OP_NOP;
    // ---------------------------------------------------------------
    // command sequencer
    // ---------------------------------------------------------------
    // state, busy flag and reset counter
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= DCPT_ST_IDLE;
            busy_r <= 1'b0;
            rst_cnt_r <= 10'h000;
            sys_reset_n_r <= 1'b1;
        end else begin
            unique case (state_r)
                DCPT_ST_IDLE: begin
                    if (cmd_take && is_call) begin
                        state_r <= DCPT_ST_STACK;
                        busy_r <= 1'b1;
                    end else if (cmd_take && is_rst) begin
                        state_r <= DCPT_ST_RESET;
                        busy_r <= 1'b1;
                        rst_cnt_r <= `DCPT_RST_CYCLES;
                        sys_reset_n_r <= 1'b0;
                    end
                end
                DCPT_ST_STACK: begin
                    // done ends the call, with or without error
                    if (stack_done_i) begin
                        state_r <= DCPT_ST_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                DCPT_ST_RESET: begin
                    if (rst_cnt_r == 10'h001) begin
                        sys_reset_n_r <= 1'b1;
                    end
                    if (rst_cnt_r != 10'h000) begin
                        rst_cnt_r <= rst_cnt_r - 10'h001;
                    end else begin
                        state_r <= DCPT_ST_IDLE;
                        busy_r <= 1'b0;
                    end
                end
            endcase
        end
    end
    // stacking request toward the core bus
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stack_req_r <= 1'b0;
            stack_addr_r <= 32'h0000_0000;
            stack_data_r <= 32'h0000_0000;
            operand_r <= 32'h0000_0000;
        end else if (cmd_take && is_call) begin
            stack_req_r <= 1'b1;
            stack_addr_r <= stack_ptr_i;
            stack_data_r <= return_pc_i;
            operand_r <= cmd_operand_i;
        end else if (stack_done_i) begin
            stack_req_r <= 1'b0;
        end
    end
    // leaving debug after a clean stacking
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_load_r <= 1'b0;
            pc_r <= 32'h0000_0000;
            flush_req_r <= 1'b0;
            bdm_exit_r <= 1'b0;
        end else begin
            pc_load_r <= 1'b0;
            flush_req_r <= 1'b0;
            bdm_exit_r <= 1'b0;
            if (state_r == DCPT_ST_STACK && stack_done_i && !stack_err_i) begin
                pc_load_r <= 1'b1;
                pc_r <= operand_r;
                flush_req_r <= 1'b1;
                bdm_exit_r <= 1'b1;
            end
        end
    end
    // reply to the serial shifter
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            resp_valid_r <= 1'b0;
            resp_r <= 17'h0_0000;
        end else begin
            resp_valid_r <= 1'b0;
            if (state_r == DCPT_ST_STACK && stack_done_i && stack_err_i) begin
                resp_valid_r <= 1'b1;
                resp_r <= `DCPT_RESP_BERR;
            end else if (state_r == DCPT_ST_RESET && rst_cnt_r == 10'h000) begin
                resp_valid_r <= 1'b1;
                resp_r <= `DCPT_RESP_DONE;
            end else if (cmd_take && is_nop) begin
                resp_valid_r <= 1'b1;
                resp_r <= `DCPT_RESP_DONE;
            end else if (cmd_take && !is_call && !is_rst && !cmd_other_i) begin
                resp_valid_r <= 1'b1;
                resp_r <= `DCPT_RESP_ILL;
            end
        end
    end
    // ---------------------------------------------------------------
    // fetch indicator
    // ---------------------------------------------------------------
    // no privilege term; loop gating
    assign ev_gate = !(loop_mode_i && recirc_i);
    assign add_w = !ev_gate ? 4'h0 :
        flush_i ? `DCPT_FETCH_FLUSH :
        fetch_i ? `DCPT_FETCH_ONE : 4'h0;
    always_comb begin
        low_nxt = low_cnt_r + add_w;
        if (low_cnt_r != 4'h0) begin
            low_nxt = low_cnt_r - 4'h1 + add_w;
        end
        if (low_nxt > `DCPT_FETCH_MAX) begin
            low_nxt = `DCPT_FETCH_MAX;
        end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt_r <= 4'h0;
            fetch_ind_n_r <= 1'b1;
        end else begin
            low_cnt_r <= low_nxt;
            fetch_ind_n_r <= (low_nxt == 4'h0);
        end
    end
    // ---------------------------------------------------------------
    // pipeline indicators
    // ---------------------------------------------------------------
    // clocked by system clock only
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pipe_use_n_r <= 1'b1;
            pipe_start_n_r <= 1'b1;
        end else if (bdm_active_i) begin
            pipe_use_n_r <= 1'b1;
            pipe_start_n_r <= serial_out_i;
        end else begin
            pipe_use_n_r <= !use_i;
            pipe_start_n_r <= !start_i;
        end
    end
    // ---------------------------------------------------------------
    // pipeline model
    // ---------------------------------------------------------------
    // queue of prefetch, decode, execute
    dcpt_pipe u_pipe (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .fetch_i(fetch_i),
        .flush_i(flush_i),
        .fetch_long_i(fetch_long_i),
        .fetch_data_i(fetch_data_i),
        .use_i(use_i),
        .start_i(start_i),
        .exe_reg_o(exe_reg_o),
        .exe_valid_o(exe_valid_o),
        .dec_valid_o(dec_valid_o)
    );
    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // reset out never reaches core state
    assign sys_reset_n_o = sys_reset_n_r;
    assign cmd_busy_o = busy_r;
    assign resp_valid_o = resp_valid_r;
    assign resp_data_o = resp_r;
    assign stack_req_o = stack_req_r;
    assign stack_addr_o = stack_addr_r;
    assign stack_data_o = stack_data_r;
    assign pc_load_o = pc_load_r;
    assign pc_value_o = pc_r;
    assign flush_req_o = flush_req_r;
    assign bdm_exit_o = bdm_exit_r;
    assign fetch_ind_n_o = fetch_ind_n_r;
    assign pipe_use_n_o = pipe_use_n_r;
    assign pipe_start_n_o = pipe_start_n_r;
    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [10:0] hlp_low_r; // consecutive reset-low cycles
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hlp_low_r <= 11'h000;
        end else if (!sys_reset_n_o) begin
            hlp_low_r <= hlp_low_r + 11'h001;
        end else begin
            hlp_low_r <= 11'h000;
        end
    end
    logic ev_any;
    assign ev_any = ev_gate && (fetch_i || flush_i);
    sequence s_lone_fetch;
        ev_gate && fetch_i && !flush_i && low_cnt_r == 4'h0 ##1 !ev_any;
    endsequence
    sequence s_lone_flush;
        ev_gate && flush_i && low_cnt_r == 4'h0 ##1 !ev_any ##1 !ev_any;
    endsequence
    AST_RST_LEN: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(sys_reset_n_o) |-> hlp_low_r == 11'h200)
        else $error("reset out not held for 512 cycles");
    AST_RST_RESP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(sys_reset_n_o) |=> resp_valid_o && resp_data_o == `DCPT_RESP_DONE)
        else $error("no done reply after reset release");
    AST_NOP_RESP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cmd_take && is_nop |=> resp_valid_o && resp_data_o == `DCPT_RESP_DONE
        && !busy_r && sys_reset_n_o)
        else $error("no-operation reply wrong");
    AST_ILL_RESP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cmd_take && !is_call && !is_rst && !is_nop && !cmd_other_i
        |=> resp_valid_o && resp_data_o == `DCPT_RESP_ILL && !busy_r)
        else $error("unknown opcode reply wrong");
    AST_CALL_PC: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cmd_take && is_call ##1 (!stack_done_i)[*3] ##1 stack_done_i && !stack_err_i
        |=> pc_load_o && bdm_exit_o && flush_req_o && pc_value_o == $past(cmd_operand_i, 5))
        else $error("patch call did not load operand");
    AST_CALL_ERR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        state_r == DCPT_ST_STACK && stack_done_i && stack_err_i
        |=> resp_valid_o && resp_data_o == `DCPT_RESP_BERR && !bdm_exit_o && !pc_load_o)
        else $error("stacking error not reported");
    AST_FETCH_ONE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lone_fetch |-> !fetch_ind_n_o ##1 fetch_ind_n_o)
        else $error("fetch indicator not one cycle");
    AST_FETCH_FLUSH: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_lone_flush |-> !fetch_ind_n_o && $past(!fetch_ind_n_o) ##1 fetch_ind_n_o)
        else $error("flush indicator not two cycles");
    AST_FETCH_THREE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ev_gate && flush_i && low_cnt_r == 4'h0 ##1 !ev_any ##1 ev_gate && fetch_i && !flush_i
        ##1 !ev_any |-> !fetch_ind_n_o && $past(!fetch_ind_n_o, 2) ##1 fetch_ind_n_o)
        else $error("flush then fetch not three cycles");
    AST_LOOP_QUIET: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        loop_mode_i && recirc_i && low_cnt_r == 4'h0 |=> fetch_ind_n_o)
        else $error("fetch flagged during recirculation");
    AST_BDM_PINS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        bdm_active_i |=> pipe_use_n_o && pipe_start_n_o == $past(serial_out_i))
        else $error("debug mode pin use wrong");
    AST_PIPE_IDLE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !bdm_active_i && !use_i && !start_i |=> pipe_use_n_o && pipe_start_n_o)
        else $error("pipe indicators not negated when idle");
endmodule : dcpt_top

// File: test/dcpt_stack_model.sv
// stack write responder standing in for memory during a patch call
// assumes the request is held until the done pulse has been seen
`timescale 1ns/1ns
module dcpt_stack_model (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic req_i,
    input wire logic fail_i,
    output logic done_o,
    output logic err_o
);
    logic [1:0] wait_r;
    // three wait cycles, then one done pulse, error flagged on demand
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {wait_r, done_o, err_o} <= 4'h0;
        end else begin
            wait_r <= (req_i && !done_o && wait_r != 2'h2) ? wait_r + 2'h1 : 2'h0;
            {done_o, err_o} <= {2{req_i && !done_o && wait_r == 2'h2}} & {1'b1, fail_i};
        end
    end
endmodule : dcpt_stack_model

// File: test/testbench.sv
// self-checking bench for the command tail and tracking pins
// assumes the stack responder model; inputs move 1 ns after edges
`timescale 1ns/1ns
module testbench;
    import dcpt_pkg::*;
    logic clk = 0, rn = 0, cv = 0, background_debug_mode = 0, so = 0, fe = 0, fl = 0, fll = 0;
    logic us = 0, st = 0, fail = 0, sd, se, busy, rv, sr, pcl, fr, bx, srst, fi, pu, ps, ev, dv;
    logic lp = 0, rc = 0;
    dcpt_word_t op = 0, exe;
    dcpt_long_t opd = 0, fd = 0, sa, sdat, pcv;
    dcpt_resp_t rd;
    int errors = 0, comparisons = 0;
    dcpt_top dut (.clk_sys_i(clk), .resetn_i(rn), .cmd_valid_i(cv), .cmd_opcode_i(op),
        .cmd_other_i(1'b0), .cmd_operand_i(opd), .return_pc_i(32'h0000_1234),
        .stack_ptr_i(32'h0000_8000), .stack_done_i(sd), .stack_err_i(se), .bdm_active_i(background_debug_mode),
        .serial_out_i(so), .loop_mode_i(lp), .recirc_i(rc), .fetch_i(fe), .flush_i(fl),
        .fetch_long_i(fll), .fetch_data_i(fd), .use_i(us), .start_i(st), .cmd_busy_o(busy),
        .resp_valid_o(rv), .resp_data_o(rd), .stack_req_o(sr), .stack_addr_o(sa),
        .stack_data_o(sdat), .pc_load_o(pcl), .pc_value_o(pcv), .flush_req_o(fr),
        .bdm_exit_o(bx), .sys_reset_n_o(srst), .fetch_ind_n_o(fi), .pipe_use_n_o(pu),
        .pipe_start_n_o(ps), .exe_reg_o(exe), .exe_valid_o(ev), .dec_valid_o(dv));
    dcpt_stack_model stk (.clk_sys_i(clk), .resetn_i(rn), .req_i(sr), .fail_i(fail),
        .done_o(sd), .err_o(se));
    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // let n edges pass, then step just past the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    // no-operation then unassigned opcode, back to back
    task automatic t_nop_ill;
        {cv, op} = {1'b1, 16'h0000};
        cyc(1);
        op = 16'h0001;
        chk({rv, rd}, 32'h0002_FFFF);
        cyc(1);
        cv = 0;
        chk({rv, rd}, 32'h0003_0000);
    endtask : t_nop_ill
    // reset out low for exactly 512 cycles, then done reply
    task automatic t_rst;
        {cv, op} = {1'b1, 16'h0400};
        cyc(1);
        cv = 0;
        chk({busy, srst}, 32'h2);
        cyc(511);
        chk(srst, 32'h0);
        cyc(1);
        chk(srst, 32'h1);
        cyc(1);
        chk({busy, rv, rd}, 32'h0002_FFFF);
    endtask : t_rst
    // patch call, with or without a stacking error
    task automatic t_call(input logic f);
        {fail, opd, cv, op} = {f, 32'h0000_4000, 1'b1, 16'h0800};
        cyc(1);
        cv = 0;
        chk(sr, 32'h1);
        chk(sa, 32'h0000_8000);
        chk(sdat, 32'h0000_1234);
        for (int i = 0; i < 8 && sr; i++) cyc(1);
        if (f) chk({pcl, bx, rv, rd}, 32'h0003_0001);
        else chk({pcl, fr, bx, busy, pcv[27:0]}, 32'hE000_4000);
    endtask : t_call
    // single fetch, then flush followed after one idle cycle by a second fetch
    task automatic t_fetch;
        fe = 1;
        cyc(1);
        fe = 0;
        chk(fi, 32'h0);
        cyc(1);
        chk(fi, 32'h1);
        fl = 1;
        cyc(1);
        fl = 0;
        chk(fi, 32'h0);
        cyc(1);
        fe = 1;
        chk(fi, 32'h0);
        cyc(1);
        fe = 0;
        chk(fi, 32'h0);
        cyc(1);
        chk(fi, 32'h1);
    endtask : t_fetch
    // loop mode: flagging stops at recirculation, resumes after
    task automatic t_loop;
        {lp, fe} = 2'b11;
        cyc(1);
        rc = 1;
        chk(fi, 32'h0);
        cyc(2);
        {lp, rc} = 2'b00;
        chk(fi, 32'h1);
        cyc(1);
        fe = 0;
        chk(fi, 32'h0);
        cyc(1);
    endtask : t_loop
    // long fetch carried by a flush, then two instruction starts and a use
    task automatic t_pipe;
        {fl, fll, fd} = {2'b11, 32'hAAAA_5555};
        cyc(1);
        {fl, fll} = 2'b00;
        cyc(3);
        st = 1;
        cyc(1);
        st = 0;
        chk({ps, ev, exe}, 32'h0001_AAAA);
        cyc(1);
        st = 1;
        cyc(1);
        {st, us} = 2'b01;
        chk({ps, ev, exe}, 32'h0001_5555);
        cyc(1);
        us = 0;
        chk({pu, ps, dv}, 32'h2);
        @(negedge clk);
        chk(pu, 32'h0);
        cyc(1);
        chk({pu, ps}, 32'h3);
    endtask : t_pipe
    // debug mode: serial bit on start pin, use pin idle
    task automatic t_bdm;
        {background_debug_mode, so, us} = 3'b101;
        cyc(1);
        {so, us} = 2'b10;
        chk({pu, ps}, 32'h2);
        cyc(1);
        background_debug_mode = 0;
        chk({pu, ps}, 32'h3);
    endtask : t_bdm
    initial begin
        forever #10 clk = ~clk;
    end
    // watchdog, well past the expected run of about 560 cycles
    initial begin
        #30000;
        errors++;
        test_done;
    end
    initial begin
        cyc(12);
        rn = 1;
        t_nop_ill;
        t_rst;
        t_call(1'b0);
        t_call(1'b1);
        t_fetch;
        t_pipe;
        t_loop;
        t_bdm;
        test_done;
    end
endmodule : testbench
